// ==== src/mft_map.vh ====
// mft_map.vh: register map, field positions, reset values, cycle counts
// assumes: included by the timer design and its monitor, byte addresses on AHB-Lite
`ifndef MFT_MAP_VH
`define MFT_MAP_VH

// byte addresses
`define MFT_ADDR_STATUS_CONTROL 12'h000
`define MFT_ADDR_COUNT_LOW 12'h004
`define MFT_ADDR_WDOG_CLEAR 12'h3F0
`define MFT_ADDR_W 12

// timer_status_control fields
`define MFT_BIT_OVF_FLAG 7
`define MFT_BIT_PER_FLAG 6
`define MFT_BIT_OVF_IE 5
`define MFT_BIT_PER_IE 4
`define MFT_BIT_OVF_CLR 3
`define MFT_BIT_PER_CLR 2
`define MFT_BIT_RATE_HI 1
`define MFT_BIT_RATE_LO 0
`define MFT_RATE_RESET 2'h3

// watchdog clear location
`define MFT_BIT_WDOG_CLR 0

// counter chain: 2 prescale stages then 15 timer stages
`define MFT_PRESCALE_W 2
`define MFT_STAGES 15
`define MFT_OVF_STAGES 10
`define MFT_PER_BASE 14
`define MFT_WDOG_W 4
`define MFT_WDOG_TICKS 4'h8

// power-on hold time in internal cycles
`define MFT_POR_CYCLES 12'hFE0
`define MFT_POR_W 12

`endif

// ==== src/mft_timer.v ====
// mft_timer.v: multifunction timer with periodic tick and watchdog
// assumes: one 40 MHz clock as the internal clock, AHB-Lite single word
// transfers, mode and option inputs synchronous to clk
//
// Function
// - overflow flag sets on low-stage wrap
// - overflow request when flag and enable; reset clears
// - overflow clear bit clears flag, reads zero
// - periodic flag sets on selected tap
// - periodic request when flag and enable
// - periodic clear bit clears flag, reads zero
// - rate field picks 2^14 to 2^17 cycles
// - watchdog clocked by selected periodic tap
// - reset sets rate select to 11
// - fifteen stages, low eight readable
// - power-on counts 4064 cycles, then clears
// - count register steps every four cycles
// - eight watchdog ticks reset the chip
// - writing zero to bit 0 clears watchdog
// - clear location reads return memory data
// - watchdog runs in run, wait, halt
// - stop clears and stops the watchdog
// - stop-to-wait option keeps watchdog alive
// - high programming voltage turns watchdog off
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mft_map.vh"

module mft_timer #(
    parameter [7:0] WDOG_ROM_DATA = 8'h00
) (
    input wire clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire sys_reset,
    input wire wdog_enable_option,
    input wire stop_to_wait_option,
    input wire stop_exec,
    input wire stop_wake,
    input wire vpp_high,
    output wire overflow_irq,
    output wire periodic_irq,
    output reg wdog_reset,
    output wire por_active
);

localparam CHAIN_W = `MFT_PRESCALE_W + `MFT_STAGES;
localparam [`MFT_POR_W-1:0] POR_LAST = `MFT_POR_CYCLES - 12'h001;

// bus state
reg wr_pend_reg;
reg [`MFT_ADDR_W-1:0] wr_addr_reg;

// timer state
reg [CHAIN_W-1:0] chain_reg;
reg [CHAIN_W-1:0] chain_next;
reg [`MFT_POR_W-1:0] por_cnt_reg;
reg por_busy_reg;
reg stopped_reg;
reg overflow_flag_reg;
reg periodic_flag_reg;
reg overflow_irq_enable_reg;
reg periodic_irq_enable_reg;
reg [1:0] rate_select_reg;
reg [`MFT_WDOG_W-1:0] wdog_cnt_reg;
reg [`MFT_WDOG_W-1:0] wdog_cnt_next;

wire addr_phase;
wire [`MFT_ADDR_W-1:0] bus_addr;
wire any_reset;
wire chain_run;
wire wr_status;
wire wr_wdog;
wire overflow_set;
wire overflow_clr;
wire periodic_set;
wire periodic_clr;
wire wdog_run;
wire wdog_clear;
wire wdog_expire;
reg periodic_tick;
reg [7:0] status_rd;

// zero wait states, always OKAY
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign addr_phase = hsel & htrans[1] & hready;
assign bus_addr = haddr[`MFT_ADDR_W-1:0];

// hsize is not checked: only whole-word transfers are used here
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= {`MFT_ADDR_W{1'b0}};
    end else begin
        wr_pend_reg <= addr_phase & hwrite;
        if (addr_phase) begin
            wr_addr_reg <= bus_addr;
        end
    end
end

assign wr_status = wr_pend_reg & (wr_addr_reg == `MFT_ADDR_STATUS_CONTROL);
assign wr_wdog = wr_pend_reg & (wr_addr_reg == `MFT_ADDR_WDOG_CLEAR);

// read view of the status/control byte; clear bits read zero
always @* begin
    status_rd = 8'h00;
    status_rd[`MFT_BIT_OVF_FLAG] = overflow_flag_reg;
    status_rd[`MFT_BIT_PER_FLAG] = periodic_flag_reg;
    status_rd[`MFT_BIT_OVF_IE] = overflow_irq_enable_reg;
    status_rd[`MFT_BIT_PER_IE] = periodic_irq_enable_reg;
    status_rd[`MFT_BIT_OVF_CLR] = 1'b0;
    status_rd[`MFT_BIT_PER_CLR] = 1'b0;
    status_rd[`MFT_BIT_RATE_HI] = rate_select_reg[1];
    status_rd[`MFT_BIT_RATE_LO] = rate_select_reg[0];
end

// read data is sampled in the address phase, so it reflects that cycle
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
        case (bus_addr)
            `MFT_ADDR_STATUS_CONTROL: begin
                hrdata <= {24'h00_0000, status_rd};
            end
            `MFT_ADDR_COUNT_LOW: begin
                hrdata <= {24'h00_0000, chain_reg[9:2]};
            end
            `MFT_ADDR_WDOG_CLEAR: begin
                hrdata <= {24'h00_0000, WDOG_ROM_DATA};
            end
            default: begin
                hrdata <= 32'h0000_0000;
            end
        endcase
    end
end

// power-on hold: counts after release of rst_b, then clears the chain
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        por_cnt_reg <= {`MFT_POR_W{1'b0}};
        por_busy_reg <= 1'b1;
    end else if (por_busy_reg) begin
        if (por_cnt_reg == POR_LAST) begin
            por_busy_reg <= 1'b0;
        end else begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
        end
    end
end

assign por_active = por_busy_reg;
assign any_reset = por_busy_reg | sys_reset | wdog_reset;

// stop turns off the timer clock unless converted to wait
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        stopped_reg <= 1'b0;
    end else if (any_reset | stop_wake) begin
        stopped_reg <= 1'b0;
    end else if (stop_exec & ~stop_to_wait_option) begin
        stopped_reg <= 1'b1;
    end
end

assign chain_run = ~stopped_reg;

// counter chain: bits [1:0] prescale, [9:2] readable, [16:2] timer
always @* begin
    chain_next = chain_reg;
    if (por_busy_reg & (por_cnt_reg == POR_LAST)) begin
        chain_next = {CHAIN_W{1'b0}};
    end else if (chain_run) begin
        chain_next = chain_reg + 1'b1;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        chain_reg <= {CHAIN_W{1'b0}};
    end else begin
        chain_reg <= chain_next;
    end
end

// overflow when the low ten stages wrap: once per 1024 cycles
assign overflow_set = chain_run & (&chain_reg[`MFT_OVF_STAGES-1:0]);

// periodic tick: one-cycle pulse when the selected tap wraps
always @* begin
    periodic_tick = 1'b0;
    if (chain_run) begin
        case (rate_select_reg)
            2'h0: begin
                periodic_tick = &chain_reg[`MFT_PER_BASE-1:0];
            end
            2'h1: begin
                periodic_tick = &chain_reg[`MFT_PER_BASE:0];
            end
            2'h2: begin
                periodic_tick = &chain_reg[`MFT_PER_BASE+1:0];
            end
            default: begin
                periodic_tick = &chain_reg[`MFT_PER_BASE+2:0];
            end
        endcase
    end
end

assign periodic_set = periodic_tick;
assign overflow_clr = wr_status & hwdata[`MFT_BIT_OVF_CLR];
assign periodic_clr = wr_status & hwdata[`MFT_BIT_PER_CLR];

// flags: writes to the flag bits themselves are ignored; set beats clear
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        overflow_flag_reg <= 1'b0;
    end else if (any_reset) begin
        overflow_flag_reg <= 1'b0;
    end else if (overflow_set) begin
        overflow_flag_reg <= 1'b1;
    end else if (overflow_clr) begin
        overflow_flag_reg <= 1'b0;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        periodic_flag_reg <= 1'b0;
    end else if (any_reset) begin
        periodic_flag_reg <= 1'b0;
    end else if (periodic_set) begin
        periodic_flag_reg <= 1'b1;
    end else if (periodic_clr) begin
        periodic_flag_reg <= 1'b0;
    end
end

// read/write control bits
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        overflow_irq_enable_reg <= 1'b0;
        periodic_irq_enable_reg <= 1'b0;
        rate_select_reg <= `MFT_RATE_RESET;
    end else if (any_reset) begin
        overflow_irq_enable_reg <= 1'b0;
        periodic_irq_enable_reg <= 1'b0;
        rate_select_reg <= `MFT_RATE_RESET;
    end else if (wr_status) begin
        overflow_irq_enable_reg <= hwdata[`MFT_BIT_OVF_IE];
        periodic_irq_enable_reg <= hwdata[`MFT_BIT_PER_IE];
        rate_select_reg <= hwdata[`MFT_BIT_RATE_HI:`MFT_BIT_RATE_LO];
    end
end

assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;
assign periodic_irq = periodic_flag_reg & periodic_irq_enable_reg;

// watchdog: option on, not stopped, programming voltage absent
assign wdog_run = wdog_enable_option & ~stopped_reg & ~vpp_high;
assign wdog_clear = wr_wdog & ~hwdata[`MFT_BIT_WDOG_CLR];
// a rate change moves the tap, so software clears first to avoid a slip
assign wdog_expire = wdog_run & periodic_tick &
    (wdog_cnt_reg == `MFT_WDOG_TICKS - 4'h1);

always @* begin
    wdog_cnt_next = wdog_cnt_reg;
    if (any_reset | wdog_clear | ~wdog_run) begin
        wdog_cnt_next = {`MFT_WDOG_W{1'b0}};
    end else if (periodic_tick) begin
        wdog_cnt_next = wdog_cnt_reg + 1'b1;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wdog_cnt_reg <= {`MFT_WDOG_W{1'b0}};
    end else begin
        wdog_cnt_reg <= wdog_cnt_next;
    end
end

// a clear write in the expiry cycle wins and suppresses the reset
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wdog_reset <= 1'b0;
    end else begin
        wdog_reset <= wdog_expire & ~wdog_clear & ~any_reset;
    end
end

endmodule // mft_timer

// ==== bench/mft_timer_monitor.sv ====
// mft_timer_monitor.sv: bus, reset and watchdog checks on the timer ports
// assumes: bound to mft_timer, single clock, rst_b async active low
`timescale 1ns/1ps
`include "mft_map.vh"
module mft_timer_monitor #(
    parameter [7:0] WDOG_ROM_DATA = 8'h00
) (
    input wire clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire sys_reset,
    input wire vpp_high,
    input wire overflow_irq,
    input wire periodic_irq,
    input wire wdog_reset,
    input wire por_active
);
    reg rd_stat_reg;
    reg rd_rom_reg;
    reg [12:0] por_cnt_reg;
    wire rd_go = hsel && htrans[1] && hready && !hwrite;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_stat_reg <= 1'b0;
            rd_rom_reg <= 1'b0;
            por_cnt_reg <= 13'h0;
        end else begin
            rd_stat_reg <= rd_go && haddr[11:0] == `MFT_ADDR_STATUS_CONTROL;
            rd_rom_reg <= rd_go && haddr[11:0] == `MFT_ADDR_WDOG_CLEAR;
            if (por_active)
                por_cnt_reg <= por_cnt_reg + 13'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_wdog_pulse;
        wdog_reset ##1 !wdog_reset;
    endsequence
    sequence s_quiet;
        !overflow_irq && !periodic_irq;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_por_length: assert property ($fell(por_active) |-> por_cnt_reg == 13'hFE0)
        else $error("power-on hold has wrong length");
    a_por_quiet: assert property (por_active |-> s_quiet)
        else $error("interrupt request during power-on hold");
    a_sysrst_clears: assert property (sys_reset |=> s_quiet)
        else $error("system reset left a request up");
    a_wdog_pulse: assert property (wdog_reset |-> s_wdog_pulse)
        else $error("watchdog reset not a single pulse");
    a_wdog_clears: assert property (wdog_reset |=> s_quiet)
        else $error("watchdog reset left a request up");
    a_vpp_off: assert property (vpp_high ##1 vpp_high |-> !wdog_reset)
        else $error("watchdog fired with high programming voltage");
    a_clear_reads_zero: assert property (rd_stat_reg |->
        hrdata[31:8] == 24'h0 && hrdata[3:2] == 2'h0)
        else $error("flag clear bits read nonzero");
    a_rom_data: assert property (rd_rom_reg |-> hrdata == {24'h0, WDOG_ROM_DATA})
        else $error("clear location read not memory data");
endmodule // mft_timer_monitor
bind mft_timer mft_timer_monitor #(.WDOG_ROM_DATA(WDOG_ROM_DATA)) i_mft_timer_monitor (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sys_reset(sys_reset), .vpp_high(vpp_high), .overflow_irq(overflow_irq),
    .periodic_irq(periodic_irq), .wdog_reset(wdog_reset), .por_active(por_active));

// ==== bench/mft_timer_bench.sv ====
// mft_timer_bench.sv: register-level tests of the timer over AHB-Lite
// assumes: hready looped back from hreadyout, run ends well under 50k cycles
`timescale 1ns/1ps
module mft_timer_bench;
    reg clk = 0, rst_b = 0, hsel = 0, hwrite = 0, sys_reset = 0, stop_exec = 0;
    reg stop_wake = 0, vpp_high = 0, wdog_en = 1, s2w = 0;
    reg [1:0] htrans = 0;
    reg [31:0] haddr = 0, hwdata = 0, d, e;
    wire [31:0] hrdata;
    wire hreadyout, hresp, ovf_irq, per_irq, wdog_reset, por_active;
    integer error_cnt = 0, tests_run = 0, n, i;
    mft_timer #(.WDOG_ROM_DATA(8'h5A)) i_mft_timer (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sys_reset(sys_reset), .wdog_enable_option(wdog_en), .stop_to_wait_option(s2w),
        .stop_exec(stop_exec), .stop_wake(stop_wake), .vpp_high(vpp_high),
        .overflow_irq(ovf_irq), .periodic_irq(per_irq), .wdog_reset(wdog_reset),
        .por_active(por_active));
    initial forever #12.5 clk = ~clk;
    task end_of_test;
        begin
            if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input reg [31:0] exp, input reg [31:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                $display("unexpected %s: expected %h seen %h", nm, exp, got);
                error_cnt = error_cnt + 1;
            end
        end
    endtask
    // address phase held until hready, then data phase held until hready
    task bus(input reg w, input reg [11:0] a, input reg [7:0] v);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            haddr <= {20'h0, a};
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            htrans <= 2'h0;
            hwdata <= {24'h0, v};
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            d = hrdata;
        end
    endtask
    // two count reads whose address phases lie 48 cycles apart
    task delta;
        begin
            bus(0, 12'h004, 8'h00);
            e = d;
            repeat (45) @(posedge clk);
            bus(0, 12'h004, 8'h00);
            d = (d - e) & 32'hFF;
        end
    endtask
    task wait_hi(input reg sel, input integer lim);
        begin
            n = 0;
            #1;
            while ((sel ? per_irq : ovf_irq) !== 1'b1 && n < lim) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            chk("irq_seen", 1, n < lim);
        end
    endtask
    task pulse_stop;
        begin
            @(posedge clk);
            stop_exec <= 1'b1;
            @(posedge clk);
            stop_exec <= 1'b0;
        end
    endtask
    initial begin
        #(25 * 60000);
        error_cnt = error_cnt + 1;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        n = 0;
        while (por_active !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n = n + 1;
        end
        chk("por_done", 0, por_active);
        bus(0, 12'h000, 8'h00);
        chk("status_reset", 32'h03, d);
        delta;
        chk("count_step", 32'h0C, d);
        bus(1, 12'h000, 8'h2B);
        bus(1, 12'h000, 8'hA3);
        bus(0, 12'h000, 8'h00);
        chk("ovf_flag_write", 32'h23, d);
        wait_hi(0, 1100);
        bus(1, 12'h000, 8'h2B);
        wait_hi(0, 1100);
        chk("ovf_period", 32'h400, n + 3);
        for (i = 0; i < 4; i = i + 1) begin
            bus(1, 12'h3F0, 8'h00);
            bus(1, 12'h000, 8'h0C | i);
            bus(0, 12'h000, 8'h00);
            chk("rate_field", i, d & 32'h73);
        end
        bus(1, 12'h3F0, 8'h00);
        bus(1, 12'h000, 8'h14);
        wait_hi(1, 16500);
        bus(1, 12'h000, 8'h14);
        wait_hi(1, 16500);
        chk("per_period", 32'h4000, n + 3);
        bus(1, 12'h3F0, 8'h00);
        bus(0, 12'h3F0, 8'h00);
        chk("clear_loc_read", 32'h5A, d);
        bus(0, 12'h100, 8'h00);
        chk("unmapped_read", 32'h0, d);
        vpp_high <= 1'b1;
        repeat (4) @(posedge clk);
        vpp_high <= 1'b0;
        pulse_stop;
        delta;
        chk("stop_freeze", 32'h0, d);
        stop_wake <= 1'b1;
        @(posedge clk);
        stop_wake <= 1'b0;
        s2w <= 1'b1;
        bus(1, 12'h3F0, 8'h00);
        pulse_stop;
        delta;
        chk("stop_to_wait", 32'h0C, d);
        sys_reset <= 1'b1;
        @(posedge clk);
        sys_reset <= 1'b0;
        bus(0, 12'h000, 8'h00);
        chk("status_sysrst", 32'h03, d);
        chk("wdog_quiet", 0, wdog_reset);
        end_of_test;
    end
endmodule // mft_timer_bench
